/* File: common/pmcs_pkg.sv */
// Constants and carrier types of the power manager clock and sleep controller
package pmcs_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] OFF_CONTROL      = 6'h00;
  localparam logic [5:0] OFF_SLEEP_CONFIG = 6'h01;
  localparam logic [5:0] OFF_CORE_DIV     = 6'h08;
  localparam logic [5:0] OFF_PERIPH_A_DIV = 6'h09;
  localparam logic [5:0] OFF_PERIPH_B_DIV = 6'h0A;
  localparam logic [5:0] OFF_PERIPH_C_DIV = 6'h0B;
  localparam logic [5:0] OFF_FAST_GATES   = 6'h14;
  localparam logic [5:0] OFF_PA_GATES     = 6'h18;
  localparam logic [5:0] OFF_PB_GATES     = 6'h1C;
  localparam logic [5:0] OFF_PC_GATES     = 6'h20;
  localparam logic [5:0] OFF_IRQ_EN_CLR   = 6'h34;
  localparam logic [5:0] OFF_IRQ_EN_SET   = 6'h35;
  localparam logic [5:0] OFF_IRQ_FLAGS    = 6'h36;
  localparam logic [5:0] OFF_RESET_CAUSE  = 6'h38;

  // Field positions
  localparam int CLOCK_READY_BIT  = 0;
  localparam int CAUSE_POR_BIT    = 0;
  localparam int CAUSE_CORE_BIT   = 1;
  localparam int CAUSE_SUPPLY_BIT = 2;
  localparam int CAUSE_EXT_BIT    = 4;
  localparam int CAUSE_WDT_BIT    = 5;
  localparam int CAUSE_SW_BIT     = 6;

  // Idle depth codes
  localparam logic [1:0] DEPTH_CORE   = 2'h0;
  localparam logic [1:0] DEPTH_FAST   = 2'h1;
  localparam logic [1:0] DEPTH_PERIPH = 2'h2;

  // Implemented gate bits, which are also their reset values
  localparam logic [31:0] GATES_FAST_IMPL = 32'h0000003F;
  localparam logic [31:0] GATES_PA_IMPL   = 32'h0000007F;
  localparam logic [31:0] GATES_PB_IMPL   = 32'h0000001F;
  localparam logic [31:0] GATES_PC_IMPL   = 32'h000FFFFF;

  // Reset values
  localparam logic [1:0] RST_SLEEP_DEPTH = 2'h0;
  localparam logic [2:0] RST_DIV_SEL     = 3'h0;

  // Reset cause capture timing
  localparam logic [1:0] CAPTURE_AT   = 2'h2;
  localparam logic [1:0] CAPTURE_DONE = 2'h3;

  typedef enum logic {PMCS_ACTIVE, PMCS_IDLE} pmcs_mode_t;

  // Avalon-MM request and answer
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pmcs_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } pmcs_bus_rsp_t;

  // Write locks from the access protection unit
  typedef struct packed {
    logic sleepCfg;
    logic coreSel;
    logic periphASel;
    logic periphBSel;
    logic periphCSel;
    logic fastGates;
    logic periphAGates;
    logic periphBGates;
    logic periphCGates;
  } pmcs_lock_t;

  // Clock enables and per-module gates toward the clock domains
  typedef struct packed {
    logic        coreTick;
    logic        fastTick;
    logic        periphATick;
    logic        periphBTick;
    logic        periphCTick;
    logic [31:0] fastGates;
    logic [31:0] periphAGates;
    logic [31:0] periphBGates;
    logic [31:0] periphCGates;
  } pmcs_clk_out_t;

  typedef struct packed {
    pmcs_mode_t    mode;
    logic [1:0]    sleepDepth;
    logic [2:0]    coreDiv;
    logic [2:0]    divA;
    logic [2:0]    divB;
    logic [2:0]    divC;
    logic [31:0]   gateFast;
    logic [31:0]   gateA;
    logic [31:0]   gateB;
    logic [31:0]   gateC;
    logic          irqEnable;
    logic          irqFlag;
    logic          irqOut;
    logic [7:0]    cause;
    logic [5:0]    causeSync1;
    logic [5:0]    causeSync2;
    logic [1:0]    captureCnt;
    logic [6:0]    divCnt;
    logic          ack;
    logic [31:0]   rdata;
    pmcs_clk_out_t clk;
  } pmcs_state_t;

  localparam pmcs_state_t PMCS_STATE_RESET = '{
    mode: PMCS_ACTIVE, sleepDepth: RST_SLEEP_DEPTH, coreDiv: RST_DIV_SEL,
    divA: RST_DIV_SEL, divB: RST_DIV_SEL, divC: RST_DIV_SEL,
    gateFast: GATES_FAST_IMPL, gateA: GATES_PA_IMPL, gateB: GATES_PB_IMPL,
    gateC: GATES_PC_IMPL, irqEnable: 1'b0, irqFlag: 1'b0, irqOut: 1'b0,
    cause: 8'h00, causeSync1: 6'h00, causeSync2: 6'h00, captureCnt: 2'h0,
    divCnt: 7'h00, ack: 1'b0, rdata: 32'h00000000,
    clk: '{coreTick: 1'b0, fastTick: 1'b0, periphATick: 1'b0, periphBTick: 1'b0,
           periphCTick: 1'b0, fastGates: 32'h00000000, periphAGates: 32'h00000000,
           periphBGates: 32'h00000000, periphCGates: 32'h00000000}};

endpackage

/* File: core/pmcs_clock_sleep.sv */
// Power manager clock prescalers, idle sleep, clock gates, interrupt and reset cause
// Function
// - Idle depth at sleep bits 1:0; code 0 stops only the core clock domain.
// - Code 1 stops core and fast system bus clock domains.
// - Code 2 also stops the peripheral bus domains; code 3 is reserved.
// - Core divider field n divides the main clock by 2 to the n.
// - First peripheral divider field divides its bus clock by 2 to the n.
// - Second peripheral divider field divides its bus clock by 2 to the n.
// - Third peripheral divider field divides its bus clock by 2 to the n.
// - Byte, halfword and word accesses work on every byte lane.
// - The protection unit can write-lock each protected register.
// - Sleep configuration reads zero after reset.
// - Core divider reads zero after reset, main clock undivided.
// - Gate bit clear stops a module clock, set runs it; reset runs.
// - Clock-ready flag sets on event; irq while flag and enable; write-one controls.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pmcs_clock_sleep
  import pmcs_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire pmcs_bus_req_t busReq,
  output pmcs_bus_rsp_t      busRsp,
  input  wire pmcs_lock_t    protectLock,
  input  wire logic          sleepReq,
  input  wire logic          deepSleepSelect,
  input  wire logic          wakeReq,
  input  wire logic          clockReadyEvent,
  input  wire logic [5:0]    resetCauseIn,
  output pmcs_clk_out_t      clkOut,
  output logic               irq
);

  pmcs_state_t s_reg;
  pmcs_state_t s_next;
  logic        busActive;
  logic        wrTake;
  logic        lane0;
  logic        clearFlag;
  logic        idleNow;
  logic        coreRun;
  logic        fastRun;
  logic        periphRun;
  logic [31:0] rdVal;

  // Tick when the low n bits of the shared counter are zero: rate is 1 / 2^n
  function automatic logic divTick(input logic [6:0] cnt, input logic [2:0] sel);
    logic [7:0] span;
    span = 8'h01 << sel;
    return (cnt & (span[6:0] - 7'h01)) == 7'h00;
  endfunction

  // Byte-lane merge for the 32-bit gate registers
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be,
                                             input logic [31:0] impl);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res & impl;
  endfunction

  // Read multiplexer; unmapped and reserved read zero
  always_comb begin
    rdVal = 32'h00000000;
    case (busReq.address)
      OFF_SLEEP_CONFIG: rdVal = {30'h00000000, s_reg.sleepDepth};
      OFF_CORE_DIV:     rdVal = {29'h00000000, s_reg.coreDiv};
      OFF_PERIPH_A_DIV: rdVal = {29'h00000000, s_reg.divA};
      OFF_PERIPH_B_DIV: rdVal = {29'h00000000, s_reg.divB};
      OFF_PERIPH_C_DIV: rdVal = {29'h00000000, s_reg.divC};
      OFF_FAST_GATES:   rdVal = s_reg.gateFast;
      OFF_PA_GATES:     rdVal = s_reg.gateA;
      OFF_PB_GATES:     rdVal = s_reg.gateB;
      OFF_PC_GATES:     rdVal = s_reg.gateC;
      OFF_IRQ_EN_CLR:   rdVal = {31'h00000000, s_reg.irqEnable};
      OFF_IRQ_EN_SET:   rdVal = {31'h00000000, s_reg.irqEnable};
      OFF_IRQ_FLAGS:    rdVal = {31'h00000000, s_reg.irqFlag};
      OFF_RESET_CAUSE:  rdVal = {24'h000000, s_reg.cause};
      default:          rdVal = 32'h00000000;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    s_next    = s_reg;
    busActive = busReq.read | busReq.write;
    wrTake    = busReq.write & s_reg.ack;
    lane0     = busReq.byteenable[0];
    clearFlag = 1'b0;

    // One wait cycle, then the answer
    s_next.ack = busActive & ~s_reg.ack;
    if (busReq.read && !s_reg.ack) begin
      s_next.rdata = rdVal;
    end

    // Register writes, taken at the edge where waitrequest is seen low
    if (wrTake) begin
      case (busReq.address)
        OFF_SLEEP_CONFIG: begin
          if (lane0 && !protectLock.sleepCfg) begin
            s_next.sleepDepth = busReq.writedata[1:0];
          end
        end
        OFF_CORE_DIV: begin
          if (lane0 && !protectLock.coreSel) begin
            s_next.coreDiv = busReq.writedata[2:0];
          end
        end
        OFF_PERIPH_A_DIV: begin
          if (lane0 && !protectLock.periphASel) begin
            s_next.divA = busReq.writedata[2:0];
          end
        end
        OFF_PERIPH_B_DIV: begin
          if (lane0 && !protectLock.periphBSel) begin
            s_next.divB = busReq.writedata[2:0];
          end
        end
        OFF_PERIPH_C_DIV: begin
          if (lane0 && !protectLock.periphCSel) begin
            s_next.divC = busReq.writedata[2:0];
          end
        end
        OFF_FAST_GATES: begin
          if (!protectLock.fastGates) begin
            s_next.gateFast = mergeBytes(s_reg.gateFast, busReq.writedata,
                                         busReq.byteenable, GATES_FAST_IMPL);
          end
        end
        OFF_PA_GATES: begin
          if (!protectLock.periphAGates) begin
            s_next.gateA = mergeBytes(s_reg.gateA, busReq.writedata,
                                      busReq.byteenable, GATES_PA_IMPL);
          end
        end
        OFF_PB_GATES: begin
          if (!protectLock.periphBGates) begin
            s_next.gateB = mergeBytes(s_reg.gateB, busReq.writedata,
                                      busReq.byteenable, GATES_PB_IMPL);
          end
        end
        OFF_PC_GATES: begin
          if (!protectLock.periphCGates) begin
            s_next.gateC = mergeBytes(s_reg.gateC, busReq.writedata,
                                      busReq.byteenable, GATES_PC_IMPL);
          end
        end
        OFF_IRQ_EN_CLR: begin
          if (lane0 && busReq.writedata[CLOCK_READY_BIT]) begin
            s_next.irqEnable = 1'b0;
          end
        end
        OFF_IRQ_EN_SET: begin
          if (lane0 && busReq.writedata[CLOCK_READY_BIT]) begin
            s_next.irqEnable = 1'b1;
          end
        end
        OFF_IRQ_FLAGS: begin
          clearFlag = lane0 & busReq.writedata[CLOCK_READY_BIT];
        end
        default: ;
      endcase
    end

    // Sticky flag; an event in the clearing cycle wins
    s_next.irqFlag = (s_reg.irqFlag & ~clearFlag) | clockReadyEvent;
    s_next.irqOut  = s_next.irqFlag & s_next.irqEnable;

    // Idle sleep entry on wait-for-interrupt with deep sleep cleared
    case (s_reg.mode)
      PMCS_ACTIVE: begin
        if (sleepReq && !deepSleepSelect) begin
          s_next.mode = PMCS_IDLE;
        end
      end
      PMCS_IDLE: begin
        if (wakeReq) begin
          s_next.mode = PMCS_ACTIVE;
        end
      end
      default: s_next.mode = PMCS_ACTIVE;
    endcase

    // Domains stopped by idle depth; reserved code acts as the deepest
    idleNow   = s_next.mode == PMCS_IDLE;
    coreRun   = ~idleNow;
    fastRun   = ~(idleNow && s_reg.sleepDepth != DEPTH_CORE);
    periphRun = ~(idleNow && s_reg.sleepDepth >= DEPTH_PERIPH);

    // Prescalers share one free counter of the main clock
    s_next.divCnt          = s_reg.divCnt + 7'h01;
    s_next.clk.coreTick    = coreRun & divTick(s_reg.divCnt, s_reg.coreDiv);
    s_next.clk.fastTick    = fastRun & divTick(s_reg.divCnt, s_reg.coreDiv);
    s_next.clk.periphATick = periphRun & divTick(s_reg.divCnt, s_reg.divA);
    s_next.clk.periphBTick = periphRun & divTick(s_reg.divCnt, s_reg.divB);
    s_next.clk.periphCTick = periphRun & divTick(s_reg.divCnt, s_reg.divC);

    // Module gates: mask bit set runs the module unless its domain sleeps
    s_next.clk.fastGates    = fastRun ? s_next.gateFast : 32'h00000000;
    s_next.clk.periphAGates = periphRun ? s_next.gateA : 32'h00000000;
    s_next.clk.periphBGates = periphRun ? s_next.gateB : 32'h00000000;
    s_next.clk.periphCGates = periphRun ? s_next.gateC : 32'h00000000;

    // Reset cause: two-stage synchroniser, caught once after release
    s_next.causeSync1 = resetCauseIn;
    s_next.causeSync2 = s_reg.causeSync1;
    if (s_reg.captureCnt != CAPTURE_DONE) begin
      s_next.captureCnt = s_reg.captureCnt + 2'h1;
    end
    if (s_reg.captureCnt == CAPTURE_AT) begin
      s_next.cause                   = 8'h00;
      s_next.cause[CAUSE_POR_BIT]    = s_reg.causeSync2[0];
      s_next.cause[CAUSE_CORE_BIT]   = s_reg.causeSync2[1];
      s_next.cause[CAUSE_SUPPLY_BIT] = s_reg.causeSync2[2];
      s_next.cause[CAUSE_EXT_BIT]    = s_reg.causeSync2[3];
      s_next.cause[CAUSE_WDT_BIT]    = s_reg.causeSync2[4];
      s_next.cause[CAUSE_SW_BIT]     = s_reg.causeSync2[5];
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= PMCS_STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign busRsp.readdata    = s_reg.rdata;
  assign busRsp.waitrequest = (busReq.read | busReq.write) & ~s_reg.ack;
  assign clkOut             = s_reg.clk;
  assign irq                = s_reg.irqOut;

endmodule

/* File: tb/pmcs_clock_sleep_monitor.sv */
// Port checker of the clock and sleep controller
`timescale 1ns/1ps
module pmcs_clock_sleep_monitor
  import pmcs_pkg::*;
(
  input wire logic          mclk,
  input wire logic          rst_b,
  input wire pmcs_bus_req_t busReq,
  input wire pmcs_bus_rsp_t busRsp,
  input wire logic          sleepReq,
  input wire logic          deepSleepSelect,
  input wire logic          wakeReq,
  input wire logic          clockReadyEvent,
  input wire pmcs_clk_out_t clkOut,
  input wire logic          irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Accepted transfers of interest
  wire logic done = (busReq.read || busReq.write) && !busRsp.waitrequest;
  wire logic rdDone = done && busReq.read;
  wire logic enClr = done && busReq.write && busReq.address == OFF_IRQ_EN_CLR;
  wire logic flClr = done && busReq.write && busReq.address == OFF_IRQ_FLAGS;
  AST_WAIT_ONE: assert property (
    $rose(busReq.read || busReq.write) |-> busRsp.waitrequest ##1 !busRsp.waitrequest)
    else $error("request not answered after one wait cycle");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(enClr || flClr) || $past(enClr || flClr, 2))
    else $error("interrupt dropped without a clearing write");
  AST_IRQ_HOLD: assert property (
    irq && clockReadyEvent && !enClr |=> irq)
    else $error("interrupt lost while an event arrived");
  AST_IDLE_CORE: assert property (
    sleepReq && !deepSleepSelect && !wakeReq ##1 !wakeReq |=> !clkOut.coreTick)
    else $error("core tick runs in idle sleep");
  AST_GATE_RST: assert property (
    !$past(rst_b, 2) && $past(rst_b) |-> clkOut.fastGates == GATES_FAST_IMPL
      && clkOut.periphAGates == GATES_PA_IMPL && clkOut.periphCGates == GATES_PC_IMPL)
    else $error("gates not enabled after reset");
  AST_TICK_RST: assert property (
    !$past(rst_b, 2) && $past(rst_b) |-> clkOut.coreTick && clkOut.fastTick
      && clkOut.periphATick && clkOut.periphBTick && clkOut.periphCTick)
    else $error("ticks divided after reset");
  AST_CTRL_ZERO: assert property (
    rdDone && busReq.address == OFF_CONTROL |-> busRsp.readdata == 32'h00000000)
    else $error("reserved control place reads nonzero");
  AST_CAUSE_RSVD: assert property (
    rdDone && busReq.address == OFF_RESET_CAUSE |->
      busRsp.readdata[31:7] == 25'h0000000 && !busRsp.readdata[3])
    else $error("reset cause reserved bits set");
endmodule
bind pmcs_clock_sleep pmcs_clock_sleep_monitor u_pmcs_clock_sleep_monitor (
  .mclk, .rst_b, .busReq, .busRsp, .sleepReq, .deepSleepSelect, .wakeReq,
  .clockReadyEvent, .clkOut, .irq);

/* File: tb/pmcs_core_model.sv */
// Model of the core and the clock domains fed by the controller
`timescale 1ns/1ps
module pmcs_core_model
  import pmcs_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire pmcs_clk_out_t clkOut,
  input  wire logic [1:0]    cmd,
  input  wire logic          clr,
  output logic               sleepReq,
  output logic               deepSleepSelect,
  output logic               wakeReq,
  output logic [4:0][15:0]   cnt
);
  // Domain ticks: core, fast bus, peripheral A, B, C
  wire logic [4:0] tk = {clkOut.periphCTick, clkOut.periphBTick, clkOut.periphATick,
                         clkOut.fastTick, clkOut.coreTick};
  // Core requests: 1 idle wait, 2 deep wait, 3 wake
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sleepReq <= 1'b0;
      deepSleepSelect <= 1'b0;
      wakeReq <= 1'b0;
      cnt <= '0;
    end else begin
      sleepReq <= cmd == 2'h1 || cmd == 2'h2;
      if (cmd == 2'h1) deepSleepSelect <= 1'b0;
      if (cmd == 2'h2) deepSleepSelect <= 1'b1;
      wakeReq <= cmd == 2'h3;
      for (int i = 0; i < 5; i++) cnt[i] <= clr ? 16'h0000 : cnt[i] + 16'(tk[i]);
    end
  end
endmodule

/* File: tb/test_power_manager_clock_sleep_regs.sv */
// Self-checking bench of the clock and sleep controller
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, e, g);
module test_power_manager_clock_sleep_regs
  import pmcs_pkg::*;
;
  logic             mclk = 1'b0;
  logic             rst_b = 1'b0;
  pmcs_bus_req_t    busReq = '0;
  pmcs_bus_rsp_t    busRsp;
  pmcs_lock_t       protectLock = '0;
  logic             clockReadyEvent = 1'b0;
  logic [5:0]       resetCauseIn = 6'h21;
  pmcs_clk_out_t    clkOut;
  logic             irq, sleepReq, deepSleepSelect, wakeReq;
  logic             clr = 1'b0;
  logic [1:0]       cmd = 2'h0;
  logic [4:0][15:0] cnt, got;
  logic [31:0]      rd;
  int               nMismatch = 0, nCompared = 0, cyc = 0;

  always #50 mclk = ~mclk;

  pmcs_clock_sleep u_pmcs_clock_sleep (.mclk, .rst_b, .busReq, .busRsp, .protectLock,
    .sleepReq, .deepSleepSelect, .wakeReq, .clockReadyEvent, .resetCauseIn, .clkOut, .irq);
  pmcs_core_model u_pmcs_core_model (.mclk, .rst_b, .clkOut, .cmd, .clr, .sleepReq,
    .deepSleepSelect, .wakeReq, .cnt);

  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // One transfer, held until waitrequest is seen low at a rising edge
  task automatic xfer(logic w, logic [5:0] a, logic [31:0] d, logic [3:0] be);
    busReq <= '{address: a, read: !w, write: w, writedata: d, byteenable: be};
    // Values read right after the edge are those the edge sampled
    do begin
      @(posedge mclk);
    end while (busRsp.waitrequest);
    rd = busRsp.readdata;
    busReq <= '0;
    @(posedge mclk);
  endtask

  task automatic wr(logic [5:0] a, logic [31:0] d, logic [3:0] be = 4'h1);
    xfer(1'b1, a, d, be);
  endtask

  task automatic rdc(string n, logic [5:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h00000000, 4'hF);
    `CHK(n, e, rd)
  endtask

  // Counts domain ticks over n cycles
  task automatic window(int n);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n) @(posedge mclk);
    @(negedge mclk);
    got = cnt;
    @(posedge mclk);
  endtask

  task automatic core(logic [1:0] c);
    cmd <= c;
    @(posedge mclk);
    cmd <= 2'h0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic pulse();
    clockReadyEvent <= 1'b1;
    @(posedge mclk);
    clockReadyEvent <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic printVerdict();
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung run short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      nMismatch++;
      printVerdict();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    // Reset values, reserved and read-only places
    rdc("sleep", OFF_SLEEP_CONFIG, 32'h00000000);
    rdc("coreDiv", OFF_CORE_DIV, 32'h00000000);
    rdc("ctrl", OFF_CONTROL, 32'h00000000);
    rdc("fastG", OFF_FAST_GATES, GATES_FAST_IMPL);
    rdc("cause", OFF_RESET_CAUSE, 32'h00000041);
    wr(OFF_RESET_CAUSE, 32'h000000FF);
    rdc("causeRo", OFF_RESET_CAUSE, 32'h00000041);
    wr(6'h02, 32'h000000FF);
    rdc("unmapped", 6'h02, 32'h00000000);
    $display("test reset done");
    // Every divider code of the core and three peripheral prescalers, byte accesses only
    for (int s = 0; s < 4; s++) begin
      for (int n = 0; n < 8; n++) begin
        wr(OFF_CORE_DIV + 6'(s), 32'(n));
        window(256);
        `CHK("divTicks", 32'(256 >> n), 32'(got[s == 0 ? 0 : s + 1]))
      end
      wr(OFF_CORE_DIV + 6'(s), 32'h00000000);
    end
    $display("test dividers done");
    // Locked registers ignore writes
    protectLock <= '1;
    wr(OFF_CORE_DIV, 32'h00000005);
    wr(OFF_SLEEP_CONFIG, 32'h00000002);
    rdc("lockDiv", OFF_CORE_DIV, 32'h00000000);
    rdc("lockSleep", OFF_SLEEP_CONFIG, 32'h00000000);
    protectLock <= '0;
    $display("test locks done");
    // Gate masks through byte and word lanes
    wr(OFF_FAST_GATES, 32'h00000015);
    rdc("fastG", OFF_FAST_GATES, 32'h00000015);
    `CHK("fastOut", 32'h00000015, clkOut.fastGates)
    wr(OFF_PC_GATES, 32'h00000000, 4'h4);
    rdc("pcG", OFF_PC_GATES, 32'h0000FFFF);
    wr(OFF_PA_GATES, 32'hFFFFFF00, 4'hF);
    rdc("paG", OFF_PA_GATES, 32'h00000000);
    `CHK("paOut", 32'h00000000, clkOut.periphAGates)
    $display("test gates done");
    // Clock-ready interrupt: enable, clear, mask
    wr(OFF_IRQ_EN_SET, 32'h00000001);
    rdc("enable", OFF_IRQ_EN_CLR, 32'h00000001);
    pulse();
    `CHK("irqOn", 32'h00000001, 32'(irq))
    pulse();
    wr(OFF_IRQ_FLAGS, 32'h00000001);
    `CHK("irqClr", 32'h00000000, 32'(irq))
    pulse();
    wr(OFF_IRQ_EN_CLR, 32'h00000001);
    `CHK("irqMask", 32'h00000000, 32'(irq))
    rdc("flag", OFF_IRQ_FLAGS, 32'h00000001);
    wr(OFF_IRQ_EN_SET, 32'h00000001);
    `CHK("irqBack", 32'h00000001, 32'(irq))
    wr(OFF_IRQ_FLAGS, 32'h00000001);
    $display("test interrupt done");
    // Idle depths stop their domains, wake resumes
    // Reserved depth code 3 is never written by software
    for (int d = 0; d < 3; d++) begin
      wr(OFF_SLEEP_CONFIG, 32'(d));
      rdc("depth", OFF_SLEEP_CONFIG, 32'(d));
      core(2'h1);
      window(32);
      `CHK("coreIdle", 32'h00000000, 32'(got[0]))
      `CHK("fastIdle", d > 0 ? 32'h00000000 : 32'h00000020, 32'(got[1]))
      `CHK("paIdle", d > 1 ? 32'h00000000 : 32'h00000020, 32'(got[2]))
      core(2'h3);
    end
    core(2'h2);
    window(32);
    `CHK("deepNoIdle", 32'h00000020, 32'(got[0]))
    $display("test sleep done");
    printVerdict();
  end
endmodule
